/* common/snf_pkg.sv */
// Shared opcodes, status layout, timing counts and pin carriers for the flash sequencer.
// Assumes a 10 MHz system clock; pins arrive raw and are synchronised inside the sequencer.
`default_nettype none

package snf_pkg;

  // Opcodes
  localparam logic [7:0] WRITE_LATCH_SET_CMD      = 8'h06;
  localparam logic [7:0] WRITE_LATCH_CLEAR_CMD    = 8'h04;
  localparam logic [7:0] IDENTIFICATION_READ_CMD  = 8'h9f;
  localparam logic [7:0] STATUS_READ_CMD          = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD         = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD           = 8'h03;
  localparam logic [7:0] FAST_ARRAY_READ_CMD      = 8'h0b;
  localparam logic [7:0] DUAL_LINE_READ_CMD       = 8'hbb;
  localparam logic [7:0] QUAD_LINE_READ_CMD       = 8'heb;
  localparam logic [7:0] PAGE_PROGRAM_CMD         = 8'h02;
  localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD    = 8'h38;
  localparam logic [7:0] CONTINUOUS_PROGRAM_CMD   = 8'had;
  localparam logic [7:0] SECURITY_STATUS_READ_CMD = 8'h2b;
  localparam logic [7:0] SECTOR_ERASE_CMD         = 8'h20;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD     = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_CMD          = 8'hd8;
  localparam logic [7:0] CHIP_ERASE_CMD_A         = 8'h60;
  localparam logic [7:0] CHIP_ERASE_CMD_B         = 8'hc7;
  localparam logic [7:0] DEEP_SLEEP_CMD           = 8'hb9;
  localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD   = 8'hab;
  localparam logic [7:0] MAKER_PART_ID_CMD_A      = 8'h90;
  localparam logic [7:0] MAKER_PART_ID_CMD_B      = 8'hef;
  localparam logic [7:0] MAKER_PART_ID_CMD_C      = 8'hdf;

  // Field layout and delivery values
  localparam int         OPCODE_BITS   = 8;
  localparam int         ADDR_BITS     = 24;
  localparam int         FAST_DUMMY    = 8;
  localparam int         SR_WIP_BIT    = 0;
  localparam int         SR_WEL_BIT    = 1;
  localparam logic [7:0] SR_WMASK      = 8'hfc;
  localparam logic [7:0] SR_RESET      = 8'h00;
  localparam int         SEC_CP_BIT    = 4;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam int         SECTOR_LG2    = 12;
  localparam int         HALF_BLK_LG2  = 15;
  localparam int         BLOCK_LG2     = 16;

  // Timing
  localparam int CLK_NS        = 100;
  localparam int CYC_PER_MS    = 1000000 / CLK_NS;
  localparam int TW_NS         = 200;
  localparam int TW_CYC        = (TW_NS / CLK_NS) < 1 ? 1 : TW_NS / CLK_NS;
  localparam int BP_US         = 300;
  localparam int BP_CYC        = BP_US * 1000 / CLK_NS;
  localparam int PP_MS         = 7;
  localparam int SE_MS         = 2000;
  localparam int HBE_MS        = 1600;
  localparam int BE_MS         = 3000;
  localparam int CE_SMALL_MS   = 13000;
  localparam int CE_LARGE_MS   = 25000;
  localparam int PP_CYC        = PP_MS * CYC_PER_MS;
  localparam int SE_CYC        = SE_MS * CYC_PER_MS;
  localparam int HBE_CYC       = HBE_MS * CYC_PER_MS;
  localparam int BE_CYC        = BE_MS * CYC_PER_MS;
  localparam int CE_CYC        = CE_SMALL_MS * CYC_PER_MS;
  localparam int CE_LARGE_CYC  = CE_LARGE_MS * CYC_PER_MS;
  localparam int CP_CYC        = 2 * BP_CYC;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } snf_pin_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] io_oe_n;
  } snf_pin_out_t;

  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_DONE, ST_IGN} snf_state_t;

endpackage : snf_pkg

`default_nettype wire

/* src/snf_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes asynchronous inputs; only q is read downstream.
`default_nettype none

module snf_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : snf_sync

`default_nettype wire

/* src/snf_sequencer.sv */
// Serial NOR flash command decoder and operation sequencer with a small array model.
// Assumes host pins oversampled by clk (SPI mode 0, sclk well below clk/4); io[1] is the serial output.
// Operation
// [RULE_01] 06 sets, 04 clears write latch
// [RULE_02] 9F id, 05 status read, 01 status write
// [RULE_03] 03 plain read, 0B read with dummy byte
// [RULE_04] Host holds dual-read dummy lines constant
// [RULE_05] Host drives quad mode nibbles, no toggling
// [RULE_06] 02 single page program, 38 quad program
// [RULE_07] Continuous program accepts only AD,04,05,2B
// [RULE_08] Continuous program drives busy while selected
// [RULE_09] Continuous program ends at top or 04
// [RULE_10] 20, 52, D8 erase sector or blocks
// [RULE_11] 60 and C7 erase whole array
// [RULE_12] B9 deep sleep, AB wakes with signature
// [RULE_13] 90, EF, DF read maker/part ids
// [RULE_14] Address bit0 picks which id first
// [RULE_15] Delivered array FF, status 00
// [RULE_16] Host waits 50 us before first select
// [RULE_17] Status write busy at most 200 ns
// [RULE_18] Sector erase busy up to 2 s
// [RULE_19] Block erases busy 1.6 s, 3 s
// [RULE_20] Chip erase busy 13 s or 25 s
// [RULE_21] Page program 7 ms, byte 300 us
// [RULE_22] Opcode MSB first; early deselect abandons
// [RULE_23] Host polls busy before next operation
`default_nettype none

module snf_sequencer
  import snf_pkg::*;
#(
  parameter int          AW      = 12,
  parameter logic [7:0]  MAN_ID  = 8'h5a, // Arbitrary identification value
  parameter logic [7:0]  TYPE_ID = 8'h3c, // Arbitrary identification value
  parameter logic [7:0]  CAP_ID  = 8'h14, // Arbitrary identification value
  parameter logic [7:0]  DEV_ID  = 8'h13, // Arbitrary identification value
  parameter int unsigned PP_T    = snf_pkg::PP_CYC,
  parameter int unsigned CP_T    = snf_pkg::CP_CYC,
  parameter int unsigned SE_T    = snf_pkg::SE_CYC,
  parameter int unsigned HBE_T   = snf_pkg::HBE_CYC,
  parameter int unsigned BE_T    = snf_pkg::BE_CYC,
  parameter int unsigned CE_T    = snf_pkg::CE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire snf_pkg::snf_pin_in_t pins_in,
  output var  snf_pkg::snf_pin_out_t pins_r
);

  localparam int DEPTH = 1 << AW;

  snf_pin_in_t     pin_s;
  logic            sclk_d_r, cs_d_r;
  logic            rise, fall, cs_rise, busy;
  snf_state_t      st_r, st_nxt;
  logic [5:0]      cnt_r, cnt_nxt;
  logic [23:0]     sh_r, sh_nxt;
  logic [7:0]      op_r, op_nxt;
  logic [23:0]     addr_r, addr_nxt;
  logic [7:0]      obyte_r, obyte_nxt;
  logic [1:0]      idx_r, idx_nxt;
  logic            wel_r, wel_nxt;
  logic            cp_r, cp_nxt;
  logic            cp_last_r, cp_last_nxt;
  logic            sleep_r, sleep_nxt;
  logic [7:0]      sr_r, sr_nxt;
  logic [31:0]     busy_cnt_r, busy_cnt_nxt;
  snf_pin_out_t    pins_nxt;
  logic [DEPTH-1:0] valid_r, valid_nxt;
  logic [7:0]      mem [DEPTH];
  logic            we;
  logic [AW-1:0]   wa;
  logic [7:0]      wd;
  logic [7:0]      status, security;
  logic            dec_go;
  logic [7:0]      opc_w;

  snf_sync #(.W(6), .RST(6'h20)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins_in),
    .q     (pin_s)
  );

  assign busy     = busy_cnt_r != 32'h0;
  assign rise     = pin_s.sclk & ~sclk_d_r & ~pin_s.cs_n;
  assign fall     = ~pin_s.sclk & sclk_d_r & ~pin_s.cs_n;
  assign cs_rise  = pin_s.cs_n & ~cs_d_r;
  assign status   = {sr_r[7:2], wel_r, busy};
  assign security = 8'(cp_r) << SEC_CP_BIT;
  assign dec_go   = rise && st_r == ST_OPC && cnt_r == 6'd7;
  assign opc_w    = {sh_r[6:0], pin_s.io[0]};

  function automatic logic [7:0] rd(input logic [23:0] a, input logic [DEPTH-1:0] v);
    rd = v[a[AW-1:0]] ? mem[a[AW-1:0]] : ERASED_BYTE; // RULE_15
  endfunction : rd

  function automatic logic [7:0] id_byte(input logic [1:0] i);
    case (i)
      2'd0:    id_byte = MAN_ID;
      2'd1:    id_byte = TYPE_ID;
      default: id_byte = CAP_ID;
    endcase
  endfunction : id_byte

  always_comb begin
    logic [7:0]    opc;
    logic [23:0]   a;
    logic [7:0]    d;
    logic          ok;
    logic          full;
    int            lg;
    logic [AW-1:0] iv;
    opc          = {sh_r[6:0], pin_s.io[0]};
    a            = {sh_r[22:0], pin_s.io[0]};
    d            = 8'h00;
    ok           = 1'b0;
    full         = 1'b0;
    lg           = 0;
    iv           = '0;
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    op_nxt       = op_r;
    addr_nxt     = addr_r;
    obyte_nxt    = obyte_r;
    idx_nxt      = idx_r;
    wel_nxt      = wel_r;
    cp_nxt       = cp_r;
    cp_last_nxt  = cp_last_r;
    sleep_nxt    = sleep_r;
    sr_nxt       = sr_r;
    pins_nxt     = pins_r;
    valid_nxt    = valid_r;
    we           = 1'b0;
    wa           = addr_r[AW-1:0];
    wd           = 8'h00;
    busy_cnt_nxt = busy ? busy_cnt_r - 32'h1 : busy_cnt_r;
    if (busy_cnt_r == 32'h1 && cp_r && cp_last_r) begin
      cp_nxt  = 1'b0; // RULE_09
      wel_nxt = 1'b0;
    end
    if (pin_s.cs_n) begin
      st_nxt           = ST_OPC; // RULE_22
      cnt_nxt          = 6'd0;
      pins_nxt.io_oe_n = 4'hf; // RULE_08
    end else if (cp_r && st_r == ST_OPC) begin
      pins_nxt.io[1]      = ~busy; // RULE_08
      pins_nxt.io_oe_n[1] = 1'b0;
    end
    if (cs_rise && !busy && (st_r == ST_DONE || st_r == ST_WDATA || st_r == ST_RDATA)) begin
      case (op_r)
        STATUS_WRITE_CMD: if (wel_r && st_r == ST_DONE) begin
          sr_nxt       = sh_r[7:0] & SR_WMASK; // RULE_02
          wel_nxt      = 1'b0;
          busy_cnt_nxt = 32'(TW_CYC); // RULE_17
        end
        PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD: if (wel_r) begin
          wel_nxt      = 1'b0;
          busy_cnt_nxt = 32'(PP_T); // RULE_21
        end
        CONTINUOUS_PROGRAM_CMD: if (wel_r && st_r == ST_DONE) begin
          cp_nxt       = 1'b1;
          cp_last_nxt  = addr_r[AW-1:0] >= AW'(DEPTH - 2); // RULE_09
          addr_nxt     = addr_r + 24'h2;
          busy_cnt_nxt = 32'(CP_T); // RULE_21
        end
        SECTOR_ERASE_CMD, HALF_BLOCK_ERASE_CMD, BLOCK_ERASE_CMD,
        CHIP_ERASE_CMD_A, CHIP_ERASE_CMD_B: if (wel_r && st_r == ST_DONE) begin
          case (op_r)
            SECTOR_ERASE_CMD: begin
              lg           = SECTOR_LG2;
              busy_cnt_nxt = 32'(SE_T); // RULE_18
            end
            HALF_BLOCK_ERASE_CMD: begin
              lg           = HALF_BLK_LG2;
              busy_cnt_nxt = 32'(HBE_T); // RULE_19
            end
            BLOCK_ERASE_CMD: begin
              lg           = BLOCK_LG2;
              busy_cnt_nxt = 32'(BE_T); // RULE_19
            end
            default: begin
              lg           = ADDR_BITS;
              busy_cnt_nxt = 32'(CE_T); // RULE_20
            end
          endcase
          for (int i = 0; i < DEPTH; i++) begin
            iv = AW'(i);
            if ((32'(iv) >> lg) == (32'(addr_r[AW-1:0]) >> lg)) begin
              valid_nxt[i] = 1'b0; // RULE_10 RULE_11
            end
          end
          wel_nxt = 1'b0;
        end
        DEEP_SLEEP_CMD:         sleep_nxt = 1'b1; // RULE_12
        DEEP_SLEEP_RELEASE_CMD: sleep_nxt = 1'b0; // RULE_12
        default: ;
      endcase
    end else if (rise) begin
      case (st_r)
        ST_OPC: begin
          sh_nxt  = {sh_r[22:0], pin_s.io[0]}; // RULE_22
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == 6'd7) begin
            cnt_nxt = 6'd0;
            op_nxt  = opc;
            if (sleep_r) begin
              ok = opc == DEEP_SLEEP_RELEASE_CMD;
            end else if (cp_r) begin
              ok = opc == CONTINUOUS_PROGRAM_CMD || opc == WRITE_LATCH_CLEAR_CMD ||
                   opc == STATUS_READ_CMD || opc == SECURITY_STATUS_READ_CMD; // RULE_07
            end else if (busy) begin
              ok = opc == STATUS_READ_CMD || opc == SECURITY_STATUS_READ_CMD;
            end else begin
              ok = 1'b1;
            end
            st_nxt = ST_IGN; // RULE_07
            if (ok) begin
              case (opc)
                WRITE_LATCH_SET_CMD: begin
                  wel_nxt = 1'b1; // RULE_01
                  st_nxt  = ST_DONE;
                end
                WRITE_LATCH_CLEAR_CMD: begin
                  wel_nxt = 1'b0; // RULE_01
                  cp_nxt  = 1'b0; // RULE_09
                  st_nxt  = ST_DONE;
                end
                IDENTIFICATION_READ_CMD: begin
                  obyte_nxt = MAN_ID; // RULE_02
                  idx_nxt   = 2'd1;
                  st_nxt    = ST_RDATA;
                end
                STATUS_READ_CMD: begin
                  obyte_nxt = status;
                  st_nxt    = ST_RDATA;
                end
                SECURITY_STATUS_READ_CMD: begin
                  obyte_nxt = security;
                  st_nxt    = ST_RDATA;
                end
                STATUS_WRITE_CMD:                    st_nxt = ST_WDATA;
                CONTINUOUS_PROGRAM_CMD:              st_nxt = cp_r ? ST_WDATA : ST_ADDR;
                CHIP_ERASE_CMD_A, CHIP_ERASE_CMD_B:  st_nxt = ST_DONE; // RULE_11
                DEEP_SLEEP_CMD:                      st_nxt = ST_DONE; // RULE_12
                ARRAY_READ_CMD, FAST_ARRAY_READ_CMD, PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD,
                SECTOR_ERASE_CMD, HALF_BLOCK_ERASE_CMD, BLOCK_ERASE_CMD, DEEP_SLEEP_RELEASE_CMD,
                MAKER_PART_ID_CMD_A, MAKER_PART_ID_CMD_B, MAKER_PART_ID_CMD_C: st_nxt = ST_ADDR; // RULE_13
                default: ;
              endcase
            end
          end
        end
        ST_ADDR: begin
          sh_nxt  = a;
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == 6'(ADDR_BITS - 1)) begin
            cnt_nxt  = 6'd0;
            addr_nxt = a;
            st_nxt   = ST_DONE; // RULE_10
            case (op_r)
              FAST_ARRAY_READ_CMD: st_nxt = ST_DUMMY; // RULE_03
              ARRAY_READ_CMD: begin
                obyte_nxt = rd(a, valid_r); // RULE_03
                st_nxt    = ST_RDATA;
              end
              DEEP_SLEEP_RELEASE_CMD: begin
                obyte_nxt = DEV_ID; // RULE_12
                st_nxt    = ST_RDATA;
              end
              MAKER_PART_ID_CMD_A, MAKER_PART_ID_CMD_B, MAKER_PART_ID_CMD_C: begin
                obyte_nxt = a[0] ? DEV_ID : MAN_ID; // RULE_14
                idx_nxt   = {1'b0, ~a[0]};
                st_nxt    = ST_RDATA;
              end
              PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD, CONTINUOUS_PROGRAM_CMD: st_nxt = ST_WDATA; // RULE_06
              default: ;
            endcase
          end
        end
        ST_DUMMY: begin
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == 6'(FAST_DUMMY - 1)) begin
            cnt_nxt   = 6'd0;
            obyte_nxt = rd(addr_r, valid_r); // RULE_03
            st_nxt    = ST_RDATA;
          end
        end
        ST_WDATA: begin
          if (op_r == QUAD_PAGE_PROGRAM_CMD) begin
            sh_nxt  = {sh_r[19:0], pin_s.io}; // RULE_06
            cnt_nxt = cnt_r + 6'd4;
          end else begin
            sh_nxt  = {sh_r[22:0], pin_s.io[0]};
            cnt_nxt = cnt_r + 6'd1;
          end
          full = cnt_nxt == 6'd8;
          d    = sh_nxt[7:0];
          if (full) begin
            cnt_nxt = 6'd0;
            if (op_r == STATUS_WRITE_CMD) begin
              st_nxt = ST_DONE;
            end else if (wel_r) begin
              we                   = 1'b1; // RULE_06
              wd                   = rd(addr_r, valid_r) & d;
              valid_nxt[addr_r[AW-1:0]] = 1'b1;
              if (op_r == CONTINUOUS_PROGRAM_CMD) begin
                addr_nxt = {addr_r[23:1], 1'b1};
                idx_nxt  = idx_r + 2'd1;
                if (idx_r[0]) begin
                  addr_nxt = {addr_r[23:1], 1'b0};
                  st_nxt   = ST_DONE;
                end
              end else begin
                addr_nxt = {addr_r[23:8], addr_r[7:0] + 8'h01};
              end
            end
          end
        end
        default: ;
      endcase
    end else if (fall && st_r == ST_RDATA) begin
      pins_nxt.io[1]      = obyte_r[7];
      pins_nxt.io_oe_n[1] = 1'b0;
      obyte_nxt           = {obyte_r[6:0], 1'b0};
      cnt_nxt             = cnt_r + 6'd1;
      if (cnt_r == 6'd7) begin
        cnt_nxt = 6'd0;
        case (op_r)
          ARRAY_READ_CMD, FAST_ARRAY_READ_CMD: begin
            addr_nxt  = addr_r + 24'h1;
            obyte_nxt = rd(addr_r + 24'h1, valid_r);
          end
          IDENTIFICATION_READ_CMD: begin
            obyte_nxt = id_byte(idx_r);
            idx_nxt   = idx_r == 2'd2 ? 2'd0 : idx_r + 2'd1;
          end
          STATUS_READ_CMD:          obyte_nxt = status;
          SECURITY_STATUS_READ_CMD: obyte_nxt = security;
          DEEP_SLEEP_RELEASE_CMD:   obyte_nxt = DEV_ID;
          default: begin
            obyte_nxt = idx_r[0] ? DEV_ID : MAN_ID; // RULE_14
            idx_nxt   = {1'b0, ~idx_r[0]};
          end
        endcase
      end
    end
    if (st_nxt == ST_OPC && st_r != ST_OPC) begin
      idx_nxt = 2'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r   <= 1'b0;
      cs_d_r     <= 1'b1;
      st_r       <= ST_OPC;
      cnt_r      <= 6'd0;
      sh_r       <= 24'h0;
      op_r       <= 8'h00;
      addr_r     <= 24'h0;
      obyte_r    <= 8'h00;
      idx_r      <= 2'd0;
      wel_r      <= 1'b0;
      cp_r       <= 1'b0;
      cp_last_r  <= 1'b0;
      sleep_r    <= 1'b0;
      sr_r       <= SR_RESET; // RULE_15
      busy_cnt_r <= 32'h0;
      pins_r     <= '{io: 4'h0, io_oe_n: 4'hf};
      valid_r    <= '0; // RULE_15
    end else begin
      sclk_d_r   <= pin_s.sclk;
      cs_d_r     <= pin_s.cs_n;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      op_r       <= op_nxt;
      addr_r     <= addr_nxt;
      obyte_r    <= obyte_nxt;
      idx_r      <= idx_nxt;
      wel_r      <= wel_nxt;
      cp_r       <= cp_nxt;
      cp_last_r  <= cp_last_nxt;
      sleep_r    <= sleep_nxt;
      sr_r       <= sr_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      pins_r     <= pins_nxt;
      valid_r    <= valid_nxt;
    end
  end

  a_wel_set_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    dec_go && !sleep_r && !cp_r && !busy && opc_w == WRITE_LATCH_SET_CMD |=> wel_r && st_r == ST_DONE)
    else $error("write latch not set by set command");
  a_wel_clear_cmd: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    dec_go && !sleep_r && opc_w == WRITE_LATCH_CLEAR_CMD |=> !wel_r && !cp_r)
    else $error("write latch or continuous mode not cleared");
  a_cp_ignore_op: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    dec_go && cp_r && !sleep_r && opc_w != CONTINUOUS_PROGRAM_CMD && opc_w != WRITE_LATCH_CLEAR_CMD &&
    opc_w != STATUS_READ_CMD && opc_w != SECURITY_STATUS_READ_CMD |=> st_r == ST_IGN && $stable(wel_r))
    else $error("foreign opcode accepted in continuous mode");
  a_cp_busy_drive: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    cp_r && busy && !pin_s.cs_n && st_r == ST_OPC |=> !pins_r.io_oe_n[1] && !pins_r.io[1])
    else $error("busy not driven in continuous mode");
  a_deselect_float: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    pin_s.cs_n |=> pins_r.io_oe_n == 4'hf)
    else $error("output driven while deselected");
  a_status_write_time: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    $rose(busy) && $past(op_r) == STATUS_WRITE_CMD |-> busy [*2] ##1 !busy)
    else $error("status write busy time wrong");
  a_sector_erase_time: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    cs_rise && !busy && wel_r && st_r == ST_DONE && op_r == SECTOR_ERASE_CMD |=> busy_cnt_r == 32'(SE_T) && !wel_r)
    else $error("sector erase busy count wrong");
  a_abandon_opcode: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
    cs_rise && st_r == ST_OPC |=> $stable(wel_r) && $stable(sleep_r) && st_r == ST_OPC)
    else $error("partial opcode took effect");
  a_id_order: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    rise && st_r == ST_ADDR && cnt_r == 6'd23 && op_r == MAKER_PART_ID_CMD_A |=>
    obyte_r == ($past(pin_s.io[0]) ? DEV_ID : MAN_ID))
    else $error("identifier order does not follow address");

endmodule : snf_sequencer

`default_nettype wire

/* tb/snf_host.sv */
// Host controller model: sends SPI mode 0 frames to the flash sequencer pins.
// Assumes clk is the system clock; sclk is high for HALF clk cycles and low for HALF + 1.
`default_nettype none

module snf_host (
  input  wire logic                  clk,
  output var snf_pkg::snf_pin_in_t   pins_in,
  input  wire snf_pkg::snf_pin_out_t pins_r
);
  timeunit 1ns;
  timeprecision 1ns;
  import snf_pkg::*;

  localparam int HALF = 6;
  logic [7:0] rx[$];
  int         drove;

  initial pins_in = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

  // Bits go out MSB first; nbits below a full byte deselects early; quad sends bytes after the fourth as nibbles
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int nbits = -1, input bit quad = 1'b0);
    int         n;
    logic [7:0] b;
    logic [7:0] sh;
    logic [2:0] lanes;
    n = quad ? 2 * tx.size() + 24 : (nbits < 0) ? 8 * (tx.size() + nrx) : nbits;
    rx = {};
    drove = 0;
    sh = 8'h00;
    @(posedge clk) pins_in.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (i < 8 * tx.size()) ? tx[i / 8] : 8'h00;
      // Unused lanes keep changing so a stale level never reads as data; dual and quad read frames hold them
      lanes = (tx[0] == DUAL_LINE_READ_CMD || tx[0] == QUAD_LINE_READ_CMD) ? pins_in.io[3:1] : ~pins_in.io[3:1];
      if (quad && i >= 32)
        @(posedge clk) pins_in.io <= 4'(tx[4 + (i - 32) / 2] >> ((i % 2) ? 0 : 4));
      else
        @(posedge clk) pins_in.io <= {lanes, b[7 - i % 8]};
      repeat (HALF - 1) @(posedge clk);
      @(posedge clk) pins_in.sclk <= 1'b1;
      // A released line reads as the inverse of its last level
      sh = {sh[6:0], pins_r.io[1] ^ pins_r.io_oe_n[1]};
      if (i >= 8 * tx.size()) begin
        drove += (pins_r.io_oe_n[1] === 1'b0);
        if (i % 8 == 7) rx.push_back(sh);
      end
      repeat (HALF - 1) @(posedge clk);
      @(posedge clk) pins_in.sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    @(posedge clk) pins_in.cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge clk);
  endtask : xfer

endmodule : snf_host

`default_nettype wire

/* tb/snf_sequencer_test.sv */
// Self-checking bench for the flash sequencer, driven through the host model.
// Assumes shortened busy counts set below; dual and quad reads are only checked to be ignored.
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module snf_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import snf_pkg::*;

  localparam logic [7:0] MAN = 8'h5a, TYP = 8'h3c, CAP = 8'h14, DEV = 8'h13; // Arbitrary identification values
  localparam int PP = 400, CP = 600, SE = 500, HBE = 600, BE = 700, CE = 800;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  snf_pin_in_t  pins_in;
  snf_pin_out_t pins_r;
  logic [7:0]   s;
  int           errors = 0;
  int           n_compared = 0;

  snf_sequencer #(.MAN_ID(MAN), .TYPE_ID(TYP), .CAP_ID(CAP), .DEV_ID(DEV), .PP_T(PP), .CP_T(CP),
                  .SE_T(SE), .HBE_T(HBE), .BE_T(BE), .CE_T(CE)) dut (
    .clk(clk), .rst_n(rst_n), .pins_in(pins_in), .pins_r(pins_r));
  snf_host host (.clk(clk), .pins_in(pins_in), .pins_r(pins_r));

  initial forever #50 clk = ~clk;

  task automatic final_report;
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic status_rd;
    host.xfer({STATUS_READ_CMD}, 1);
    s = host.rx[0];
  endtask : status_rd

  task automatic write_latch_set_cmd;
    host.xfer({WRITE_LATCH_SET_CMD}, 0);
  endtask : write_latch_set_cmd

  // Busy must show at once and clear within t / 200 + 2 further status polls
  task automatic wait_ready(input int t);
    int k;
    k = 0;
    status_rd;
    `CHK(s[SR_WIP_BIT], 1'b1)
    while (s[SR_WIP_BIT] === 1'b1 && k < t / 200 + 2) begin
      status_rd;
      k++;
    end
    `CHK(s[SR_WIP_BIT], 1'b0)
  endtask : wait_ready

  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    write_latch_set_cmd;
    host.xfer({PAGE_PROGRAM_CMD, 8'h00, a, 8'h00, d}, 0);
    wait_ready(PP);
  endtask : prog

  task automatic t_delivery;
    status_rd;
    `CHK(s, SR_RESET)
    host.xfer({ARRAY_READ_CMD, 8'h00, 8'h01, 8'h00}, 2);
    `CHK({host.rx[0], host.rx[1]}, {ERASED_BYTE, ERASED_BYTE})
  endtask : t_delivery

  task automatic t_ids;
    logic [7:0] ops[3] = '{MAKER_PART_ID_CMD_A, MAKER_PART_ID_CMD_B, MAKER_PART_ID_CMD_C};
    host.xfer({IDENTIFICATION_READ_CMD}, 3);
    `CHK({host.rx[0], host.rx[1], host.rx[2]}, {MAN, TYP, CAP})
    foreach (ops[i]) for (int a = 0; a < 2; a++) begin
      host.xfer({ops[i], 8'h00, 8'h00, 8'(a)}, 2);
      `CHK({host.rx[0], host.rx[1]}, a ? {DEV, MAN} : {MAN, DEV})
    end
  endtask : t_ids

  task automatic t_latch;
    host.xfer({WRITE_LATCH_SET_CMD}, 0, 4);
    status_rd;
    `CHK(s[SR_WEL_BIT], 1'b0)
    write_latch_set_cmd;
    status_rd;
    `CHK(s[SR_WEL_BIT], 1'b1)
    host.xfer({WRITE_LATCH_CLEAR_CMD}, 0);
    status_rd;
    `CHK(s[SR_WEL_BIT], 1'b0)
  endtask : t_latch

  task automatic t_status_write;
    write_latch_set_cmd;
    host.xfer({STATUS_WRITE_CMD, 8'hfc}, 0);
    status_rd;
    `CHK({s[7:2], s[SR_WIP_BIT]}, 7'h7e)
    write_latch_set_cmd;
    host.xfer({STATUS_WRITE_CMD, 8'h00}, 0);
    status_rd;
    `CHK({s[7:2], s[SR_WIP_BIT]}, 7'h00)
  endtask : t_status_write

  task automatic t_program;
    host.xfer({PAGE_PROGRAM_CMD, 8'h00, 8'h02, 8'h00, 8'h00}, 0);
    write_latch_set_cmd;
    host.xfer({PAGE_PROGRAM_CMD, 8'h00, 8'h01, 8'h00, 8'ha5, 8'h3c}, 0);
    wait_ready(PP);
    host.xfer({FAST_ARRAY_READ_CMD, 8'h00, 8'h01, 8'h00, 8'h00}, 2);
    `CHK({host.rx[0], host.rx[1]}, 16'ha53c)
    host.xfer({ARRAY_READ_CMD, 8'h00, 8'h02, 8'h00}, 1);
    `CHK(host.rx[0], ERASED_BYTE)
    write_latch_set_cmd;
    host.xfer({QUAD_PAGE_PROGRAM_CMD, 8'h00, 8'h03, 8'h00, 8'h96, 8'h5a}, 0, -1, 1'b1);
    wait_ready(PP);
    host.xfer({ARRAY_READ_CMD, 8'h00, 8'h03, 8'h00}, 2);
    `CHK({host.rx[0], host.rx[1]}, 16'h965a)
  endtask : t_program

  task automatic t_erase;
    logic [7:0] ops[5] = '{SECTOR_ERASE_CMD, HALF_BLOCK_ERASE_CMD, BLOCK_ERASE_CMD, CHIP_ERASE_CMD_A, CHIP_ERASE_CMD_B};
    int         tm[5] = '{SE, HBE, BE, CE, CE};
    foreach (ops[i]) begin
      prog(8'h01, 8'h00);
      write_latch_set_cmd;
      if (i < 3)
        host.xfer({ops[i], 8'h00, 8'h01, 8'h00}, 0);
      else
        host.xfer({ops[i]}, 0);
      wait_ready(tm[i]);
      host.xfer({ARRAY_READ_CMD, 8'h00, 8'h01, 8'h00}, 1);
      `CHK(host.rx[0], ERASED_BYTE)
    end
  endtask : t_erase

  task automatic t_cont;
    write_latch_set_cmd;
    host.xfer({CONTINUOUS_PROGRAM_CMD, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22}, 0);
    wait_ready(CP);
    host.xfer({SECURITY_STATUS_READ_CMD}, 1);
    `CHK(host.rx[0][SEC_CP_BIT], 1'b1)
    host.xfer({SECTOR_ERASE_CMD, 8'h00, 8'h00, 8'h00}, 0);
    status_rd;
    `CHK(s[SR_WIP_BIT], 1'b0)
    host.xfer({WRITE_LATCH_CLEAR_CMD}, 0);
    host.xfer({SECURITY_STATUS_READ_CMD}, 1);
    `CHK(host.rx[0][SEC_CP_BIT], 1'b0)
    host.xfer({ARRAY_READ_CMD, 8'h00, 8'h00, 8'h00}, 2);
    `CHK({host.rx[0], host.rx[1]}, 16'h1122)
  endtask : t_cont

  task automatic t_sleep;
    host.xfer({DUAL_LINE_READ_CMD}, 1);
    `CHK(host.drove, 0)
    host.xfer({QUAD_LINE_READ_CMD}, 1);
    `CHK(host.drove, 0)
    host.xfer({DEEP_SLEEP_CMD}, 0);
    host.xfer({STATUS_READ_CMD}, 1);
    `CHK(host.drove, 0)
    host.xfer({DEEP_SLEEP_RELEASE_CMD, 8'h00, 8'h00, 8'h00}, 1);
    `CHK(host.rx[0], DEV)
    host.xfer({STATUS_READ_CMD}, 1);
    `CHK(host.drove, 8)
  endtask : t_sleep

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (500) @(posedge clk);
    t_delivery;
    t_ids;
    t_latch;
    t_status_write;
    t_program;
    t_erase;
    t_cont;
    t_sleep;
    final_report;
  end

  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    final_report;
  end

endmodule : snf_sequencer_test

`default_nettype wire
